// File: serial_port_pkg.sv
package serial_port_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] CTRL_IDX   = 10'h0C4;  // channel_control_reg
  localparam logic [9:0] STATUS_IDX = 10'h0C5;  // channel_status_reg
  localparam logic [9:0] LOWER_IDX  = 10'h0C6;  // serial_data_lower
  localparam logic [9:0] UPPER_IDX  = 10'h0C7;  // serial_data_high_byte

  // Control register field positions
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_MASTER_BIT = 5;
  localparam int CTRL_CLOCK_POLARITY_BIT   = 4;
  localparam int CTRL_CLOCK_PHASE_BIT   = 3;
  localparam int CTRL_RATE_LSB   = 0;

  // Status register field positions
  localparam int STAT_DONE_BIT  = 7;
  localparam int STAT_WRITE_COLLISION_FLAG_BIT  = 6;
  localparam int STAT_EMPTY_BIT = 3;
  localparam int STAT_ORDER_BIT = 2;
  localparam int STAT_WIDE_BIT  = 1;
  localparam int STAT_IRQEN_BIT = 0;

  // Reset values
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  UPPER_RESET  = 8'h00;
  localparam logic [15:0] DATA_RESET   = 16'h0000;

  // Last serial edge index of a frame (two edges per bit)
  localparam logic [4:0] LAST_EDGE_8  = 5'h0F;
  localparam logic [4:0] LAST_EDGE_16 = 5'h1F;

  // Answer for an unmapped read
  localparam logic [31:0] READ_NONE = 32'h0000_0000;

endpackage

// File: serial_port.sv
// Functional notes
// - Upper byte first; lower byte write starts word
// - Upper byte used only in 16-bit framing
// - Data write loads transmit, read gives receive
// - Shift out and in on same clock
// - Unselected slave releases its data output
// - Unselected slave ignores serial clock entirely
// - Eight serial clocks move one byte
// - Master select bit chooses master or slave
// - Master starts shifting as soon as loaded
// - Write during transfer sets collision, ignored
// - Frame end sets done flag, interrupt
// - Receive assembled in selected bit order
// - Slave counts clock edges to full frame
// - Slave holds data while done flag set
// - Unloaded slave sends an all-zero byte
// - Polarity and phase give four modes
// - Both ends use identical polarity, phase
// - Phase zero captures on first edge
// - Phase one drives first, captures second
// - Collision stays set, no interrupt, no abort
// - Polarity sets the idle clock level
// - Rate field divides clock by powers of two
// - Width bit picks 8- or 16-bit frames
`timescale 1ns/1ns
module serial_port
  import serial_port_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial clock pin
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOe,
  // Master-out data pin
  input  wire logic        mosiIn,
  output logic             mosiOut,
  output logic             mosiOe,
  // Master-in data pin
  input  wire logic        misoIn,
  output logic             misoOut,
  output logic             misoOe,
  // Slave select, active low
  input  wire logic        slaveSelN,
  // Interrupt request
  output logic             irq
);

  // All state of the block
  typedef struct packed {
    logic        enable;     // Channel on
    logic        master;     // master_select
    logic        clock_polarity;       // clock_polarity
    logic        clock_phase;       // clock_phase
    logic [2:0]  rate;       // rate_divider_field
    logic        done;       // transfer_done_flag
    logic        write_collision_flag;       // write_collision_flag
    logic        order;      // bit_order_select
    logic        wide;       // frame_width_select
    logic        irqEn;      // Interrupt enable
    logic [7:0]  upper;      // serial_data_upper holding byte
    logic [15:0] txShift;    // Transmit shift register
    logic        txLoaded;   // Transmit register holds data
    logic [15:0] rxShift;    // Receive shift register
    logic [15:0] rxData;     // Last complete received word
    logic        busy;       // Frame in progress
    logic [4:0]  edgeCnt;    // Serial edges seen in frame
    logic [6:0]  divCnt;     // Half-period divider
    logic        sckOut;     // Serial clock driven out
    logic        sckOe;      // Serial clock enable
    logic        dataOut;    // Serial data driven out
    logic        mosiOe;     // Master data enable
    logic        misoOe;     // Slave data enable
    logic        irq;        // Interrupt request
    logic [2:0]  sckSync;    // Clock synchroniser plus history
    logic [1:0]  dinSync;    // Data input synchroniser
    logic [1:0]  selSync;    // Select synchroniser
    logic        selPrev;    // Select history
    logic        pready;     // APB ready
    logic        pslverr;    // APB error
    logic [31:0] prdata;     // APB read data
  } state_t;

  state_t s_q;               // Registered state
  state_t s_d;               // Next state

  // Combinational helpers
  logic        curBit;       // Bit to send next
  logic [15:0] txNext;       // Transmit register after one shift
  logic [15:0] rxNext;       // Receive register with new bit
  logic        lastEdge;     // Current edge ends the frame
  logic [6:0]  halfLast;     // Divider terminal count
  logic        edgeEv;       // A serial clock edge to process
  logic        startEv;      // A frame begins
  logic        selected;     // Select is active
  logic        slaveOn;      // Slave mode and selected
  logic        doneSet;      // Engine sets done this cycle
  logic        setupPh;      // APB setup cycle
  logic        accessPh;     // APB completing access
  logic [9:0]  regIdx;       // Word index of the access
  logic        hit;          // Access maps to a register
  logic [31:0] readVal;      // Read data for the access

  // Next-state logic
  always_comb begin
    s_d      = s_q;
    edgeEv   = 1'b0;
    startEv  = 1'b0;
    doneSet  = 1'b0;
    readVal  = READ_NONE;
    regIdx   = paddr[11:2];
    setupPh  = psel && !penable;
    accessPh = psel && penable && s_q.pready;
    selected = !s_q.selSync[1];
    slaveOn  = s_q.enable && !s_q.master && selected;

    // Next transmit bit and shifted word, in chosen order
    if (s_q.order) begin
      curBit = s_q.txShift[0];
      txNext = s_q.txShift >> 1;
    end else begin
      curBit = s_q.wide ? s_q.txShift[15] : s_q.txShift[7];
      txNext = s_q.txShift << 1;
    end

    // Receive assembly follows the transmit order
    if (!s_q.order) begin
      rxNext = {s_q.rxShift[14:0], s_q.dinSync[1]};
    end else if (s_q.wide) begin
      rxNext = {s_q.dinSync[1], s_q.rxShift[15:1]};
    end else begin
      rxNext = {8'h00, s_q.dinSync[1], s_q.rxShift[7:1]};
    end

    // Two edges per bit; frame length from width bit
    lastEdge = s_q.edgeCnt == (s_q.wide ? LAST_EDGE_16 : LAST_EDGE_8);

    // Half period of 2^(rate-1) cycles, at least one
    if (s_q.rate == 3'h0) begin
      halfLast = 7'h00;
    end else begin
      halfLast = 7'((7'h01 << (s_q.rate - 3'h1)) - 7'h01);
    end

    // Pin synchronisers, two flops before any use
    s_d.sckSync = {s_q.sckSync[1], s_q.sckSync[0], sckIn};
    s_d.dinSync = {s_q.dinSync[0], s_q.master ? misoIn : mosiIn};
    s_d.selSync = {s_q.selSync[0], slaveSelN};
    s_d.selPrev = s_q.selSync[1];

    // Serial clock source: own divider or synced pin
    if (s_q.enable && s_q.master) begin
      if (!s_q.busy) begin
        s_d.sckOut = s_q.clock_polarity;
        s_d.divCnt = 7'h00;
        if (s_q.txLoaded) begin
          // Start at once when data is waiting
          s_d.busy    = 1'b1;
          s_d.edgeCnt = 5'h00;
          startEv     = 1'b1;
        end
      end else if (s_q.divCnt == halfLast) begin
        // Half period elapsed, toggle the clock
        s_d.divCnt = 7'h00;
        s_d.sckOut = !s_q.sckOut;
        edgeEv     = 1'b1;
      end else begin
        s_d.divCnt = s_q.divCnt + 7'h01;
      end
    end else if (slaveOn && !s_q.done) begin
      s_d.sckOut = s_q.clock_polarity;
      // Select falling: first bit must be ready
      if (s_q.selPrev && !s_q.busy) begin
        s_d.edgeCnt = 5'h00;
        startEv     = 1'b1;
      end
      // Each synced clock transition is one edge
      if (s_q.sckSync[1] != s_q.sckSync[2]) begin
        edgeEv = 1'b1;
      end
    end else begin
      // Idle, disabled, deselected or holding data
      s_d.busy    = 1'b0;
      s_d.edgeCnt = 5'h00;
      s_d.divCnt  = 7'h00;
      s_d.sckOut  = s_q.clock_polarity;
    end

    // Phase zero: first bit out before first edge
    if (startEv && !s_q.clock_phase) begin
      s_d.dataOut = curBit;
      s_d.txShift = txNext;
    end

    // Edge handling: even edges lead, odd edges trail
    if (edgeEv) begin
      s_d.busy    = 1'b1;
      s_d.edgeCnt = s_q.edgeCnt + 5'h01;
      if (s_q.edgeCnt[0] == s_q.clock_phase) begin
        // Capture edge, same clock as the output shift
        s_d.rxShift = rxNext;
      end else if (s_q.clock_phase || !lastEdge) begin
        // Launch edge
        s_d.dataOut = curBit;
        s_d.txShift = txNext;
      end
      if (lastEdge) begin
        // Frame complete
        s_d.busy     = 1'b0;
        s_d.edgeCnt  = 5'h00;
        s_d.txLoaded = 1'b0;
        s_d.txShift  = DATA_RESET;
        // Take the register as it stands after this edge: a trailing launch edge adds no bit
        s_d.rxData   = s_q.wide ? s_d.rxShift : {8'h00, s_d.rxShift[7:0]};
        doneSet      = 1'b1;
      end
    end
    if (doneSet) begin
      s_d.done = 1'b1;
    end

    // Pin drivers
    s_d.sckOe  = s_q.enable && s_q.master;
    s_d.mosiOe = s_q.enable && s_q.master;
    s_d.misoOe = slaveOn;

    // Interrupt on done only, never on collision
    s_d.irq = s_q.done && s_q.irqEn;

    // Register decode
    hit = 1'b1;
    case (regIdx)
      CTRL_IDX: begin
        readVal[CTRL_ENABLE_BIT] = s_q.enable;
        readVal[CTRL_MASTER_BIT] = s_q.master;
        readVal[CTRL_CLOCK_POLARITY_BIT]   = s_q.clock_polarity;
        readVal[CTRL_CLOCK_PHASE_BIT]   = s_q.clock_phase;
        readVal[CTRL_RATE_LSB +: 3] = s_q.rate;
      end
      STATUS_IDX: begin
        readVal[STAT_DONE_BIT]  = s_q.done;
        readVal[STAT_WRITE_COLLISION_FLAG_BIT]  = s_q.write_collision_flag;
        readVal[STAT_EMPTY_BIT] = !s_q.txLoaded;
        readVal[STAT_ORDER_BIT] = s_q.order;
        readVal[STAT_WIDE_BIT]  = s_q.wide;
        readVal[STAT_IRQEN_BIT] = s_q.irqEn;
      end
      LOWER_IDX: begin
        readVal[7:0] = s_q.rxData[7:0];
      end
      UPPER_IDX: begin
        readVal[7:0] = s_q.rxData[15:8];
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    // APB: ready one cycle after setup, answer then
    s_d.pready = setupPh && !s_q.pready;
    if (setupPh) begin
      s_d.prdata  = pwrite ? READ_NONE : readVal;
      s_d.pslverr = !hit;
    end

    // Register writes at the completing edge
    if (accessPh && pwrite && pstrb[0] && hit) begin
      case (regIdx)
        CTRL_IDX: begin
          s_d.enable = pwdata[CTRL_ENABLE_BIT];
          s_d.master = pwdata[CTRL_MASTER_BIT];
          s_d.clock_polarity   = pwdata[CTRL_CLOCK_POLARITY_BIT];
          s_d.clock_phase   = pwdata[CTRL_CLOCK_PHASE_BIT];
          s_d.rate   = pwdata[CTRL_RATE_LSB +: 3];
        end
        STATUS_IDX: begin
          // Writing zero clears a flag; a new set wins
          if (!pwdata[STAT_DONE_BIT] && !doneSet) begin
            s_d.done = 1'b0;
          end
          if (!pwdata[STAT_WRITE_COLLISION_FLAG_BIT]) begin
            s_d.write_collision_flag = 1'b0;
          end
          s_d.order = pwdata[STAT_ORDER_BIT];
          s_d.wide  = pwdata[STAT_WIDE_BIT];
          s_d.irqEn = pwdata[STAT_IRQEN_BIT];
        end
        LOWER_IDX: begin
          if (s_q.txLoaded || s_q.busy) begin
            // Shifting word untouched, frame goes on
            s_d.write_collision_flag = 1'b1;
          end else begin
            // Lower byte write launches the word
            s_d.txShift  = s_q.wide ? {s_q.upper, pwdata[7:0]}
                                    : {8'h00, pwdata[7:0]};
            s_d.txLoaded = 1'b1;
          end
        end
        UPPER_IDX: begin
          s_d.upper = pwdata[7:0];
        end
        default: begin
          s_d.upper = s_q.upper;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.upper    <= UPPER_RESET;
      s_q.txShift  <= DATA_RESET;
      s_q.rxShift  <= DATA_RESET;
      s_q.rxData   <= DATA_RESET;
      s_q.sckSync  <= 3'h0;
      s_q.selSync  <= 2'h3;
      s_q.selPrev  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign sckOut  = s_q.sckOut;
  assign sckOe   = s_q.sckOe;
  assign mosiOut = s_q.dataOut;
  assign mosiOe  = s_q.mosiOe;
  assign misoOut = s_q.dataOut;
  assign misoOe  = s_q.misoOe;
  assign irq     = s_q.irq;

endmodule

// File: serial_port_checker.sv
`timescale 1ns/1ns
module serial_port_checker
  import serial_port_pkg::*;
(
  // Clock, reset, bus
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Pins
  input wire logic        sckOut,
  input wire logic        sckOe,
  input wire logic        mosiOe,
  input wire logic        misoOe,
  input wire logic        slaveSelN,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] ctrl_q;  // Control shadow
  logic [7:0] stat_q;  // Status shadow
  logic       wrCtrl;  // Control write edge
  logic       wrStat;  // Status write edge
  assign wrCtrl = psel && penable && pready && pwrite && paddr[11:2] == CTRL_IDX;
  assign wrStat = psel && penable && pready && pwrite && paddr[11:2] == STATUS_IDX;
  // Follow configuration writes
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RESET;
      stat_q <= STATUS_RESET;
    end else begin
      if (wrCtrl) ctrl_q <= pwdata[7:0];
      if (wrStat) stat_q <= pwdata[7:0];
    end
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_read_top_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read upper bits set");
  a_miso_released: assert property ((slaveSelN && !ctrl_q[5])[*5] |-> !misoOe)
    else $error("unselected slave drives data");
  a_master_drives: assert property ((ctrl_q[7] && ctrl_q[5])[*3] |->
    sckOe && mosiOe && !misoOe)
    else $error("master pins not driven");
  a_slave_no_clock: assert property ((!ctrl_q[5])[*3] |-> !sckOe && !mosiOe)
    else $error("slave drives clock");
  a_irq_enabled: assert property ($rose(irq) |-> $past(stat_q[0]))
    else $error("interrupt while disabled");
  a_irq_cleared: assert property (wrStat && !pwdata[7] |=> ##1 !irq)
    else $error("interrupt not cleared");
  a_sck_half: assert property ($changed(sckOut) && ctrl_q[2:0] > 3'h1 &&
    $stable(ctrl_q) |=> $stable(sckOut))
    else $error("serial clock half too short");
  // Main scenarios reached
  cover property ($rose(irq));
  cover property ($rose(misoOe));
  cover property (wrStat && pwdata[7]);
endmodule

// File: spi_far_end.sv
`timescale 1ns/1ns
module spi_far_end (
  // Clock and pins
  input  wire logic        core_clk,
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic        selN,
  output logic             miso,
  // Phase and words
  input  wire logic        clock_phase,
  input  wire logic [15:0] txWord,
  output logic [15:0]      rxWord
);
  logic [16:0] shift_q;         // Top bit is on the line
  logic        sck_q;           // Clock level seen, never driven back
  logic        lead_q;          // Next edge leads
  logic        noise_q = 1'b0;  // Released line pattern
  // Released line toggles so stale data never matches
  assign miso = selN ? noise_q : shift_q[16];
  // Load while deselected, step on serial edges
  always @(posedge core_clk) begin
    sck_q <= sck;
    noise_q <= ~noise_q;
    if (selN) begin
      shift_q <= clock_phase ? {~txWord[15], txWord} : {txWord, 1'b0};
      rxWord <= 16'h0000;
      lead_q <= 1'b1;
    end else if (sck !== sck_q) begin
      lead_q <= ~lead_q;
      if (lead_q == clock_phase) shift_q <= {shift_q[15:0], 1'b0};
      else rxWord <= {rxWord[14:0], mosi};
    end
  end
endmodule

// File: usci_spi_master_slave_tb_top.sv
`timescale 1ns/1ns
module usci_spi_master_slave_tb_top;
  import serial_port_pkg::*;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic        sckIn, sckOut, sckOe, mosiIn, mosiOut, mosiOe, wide, lsb;
  logic        misoIn, misoOut, misoOe, slaveSelN, farCpha;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] farTx, farRx, w, p, e, g, mask;
  logic [7:0]  b, got;
  logic [2:0]  rate;
  int          errCount, checksDone, nb, n;
  integer      seed;
  serial_port i_serial_port (.*);
  spi_far_end i_spi_far_end (.core_clk, .sck(sckOut), .mosi(mosiOut), .selN(slaveSelN),
    .miso(misoIn), .clock_phase(farCpha), .txWord(farTx), .rxWord(farRx));
  // Clock
  always #4 core_clk = ~core_clk;
  // Verdict
  task automatic summarize;
    if (errCount == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Compare seen against expected
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checksDone++;
    if (s !== x) begin
      errCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // One APB transfer after an idle cycle
  task automatic apb(input logic [11:0] a, input logic wr, input logic [7:0] d);
    @(posedge core_clk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= {24'($random(seed)), d};
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait for ready; only the watchdog bounds this wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [7:0] x);
    apb(a, 1'b0, 8'h00);
    check(rd, {24'h0, x});
  endtask
  // Wait for the interrupt, bounded only by the watchdog
  task automatic waitIrq;
    while (irq !== 1'b1) @(posedge core_clk);
  endtask
  // Bench acting as master on the slave pins
  task automatic sByte(input logic [7:0] v, output logic [7:0] s);
    for (int i = 7; i >= 0; i--) begin
      mosiIn <= v[i];
      repeat (6) @(posedge core_clk);
      sckIn <= 1'b1;
      s[i] = misoOut;
      repeat (6) @(posedge core_clk);
      sckIn <= 1'b0;
    end
    // Let the synced last edge reach the receive register
    repeat (6) @(posedge core_clk);
  endtask
  function automatic logic [15:0] rev(input logic [15:0] v, input int k);
    rev = 16'h0000;
    for (int i = 0; i < k; i++) rev[i] = v[k-1-i];
  endfunction
  // Watchdog
  initial begin
    repeat (40000) @(posedge core_clk);
    errCount++;
    summarize();
  end
  initial begin
    {core_clk, resetn, psel, penable, pwrite, sckIn, mosiIn, farCpha} = 8'h00;
    {paddr, pwdata, farTx} = 60'h0;
    pstrb = 4'hF;
    slaveSelN = 1'b1;
    seed = 32'h936F;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    rdChk(12'h310, CTRL_RESET);
    rdChk(12'h314, STATUS_RESET | 8'(1 << STAT_EMPTY_BIT)); // Idle transmit reads empty
    rdChk(12'h31C, UPPER_RESET);
    apb(12'h320, 1'b1, 8'hFF);
    rdChk(12'h320, READ_NONE[7:0]);
    check(er, 1'b1);
    // Four clock modes, random framing and data
    for (int m = 0; m < 4; m++) begin
      {wide, lsb} = 2'($random(seed));
      rate = 3'(3 + {$random(seed)} % 3);
      nb = wide ? 16 : 8;
      mask = wide ? 16'hFFFF : 16'h00FF;
      w = 16'($random(seed));
      p = 16'($random(seed));
      e = lsb ? rev(w, nb) : w & mask;
      g = lsb ? rev(p, nb) : p & mask;
      farTx <= wide ? p : {p[7:0], 8'h00};
      farCpha <= m[0];
      apb(12'h310, 1'b1, {3'h5, m[1], m[0], rate});
      apb(12'h314, 1'b1, {5'h0, lsb, wide, 1'b1});
      repeat (3) @(posedge core_clk);
      check(sckOut, m[1]);
      slaveSelN <= 1'b0;
      apb(12'h31C, 1'b1, w[15:8]);
      apb(12'h318, 1'b1, w[7:0]);
      if (m == 1) apb(12'h318, 1'b1, ~w[7:0]);
      waitIrq();
      repeat (3) @(posedge core_clk);
      check(irq, 1'b1);
      check(farRx, e);
      check(sckOut, m[1]);
      rdChk(12'h318, g[7:0]);
      if (wide) rdChk(12'h31C, g[15:8]);
      apb(12'h314, 1'b0, 8'h00);
      check(rd & 32'hF7, {24'h0, 1'b1, m == 1, 3'h0, lsb, wide, 1'b1});
      slaveSelN <= 1'b1;
      apb(12'h314, 1'b1, {5'h0, lsb, wide, 1'b1});
      repeat (3) @(posedge core_clk);
      check(irq, 1'b0);
    end
    // Every rate, half period measured
    for (int r = 0; r < 8; r++) begin
      apb(12'h310, 1'b1, {5'h14, r[2:0]});
      apb(12'h318, 1'b1, 8'hA5);
      for (n = 0; n < 300 && sckOut === 1'b0; n++) @(posedge core_clk);
      for (n = 0; n < 300 && (n == 0 || sckOut === 1'b1); n++) @(posedge core_clk);
      check(n, r < 2 ? 1 : 1 << (r - 1));
      waitIrq();
      apb(12'h314, 1'b1, 8'h01);
    end
    // Slave mode driven from the pins
    apb(12'h310, 1'b1, 8'h80);
    sByte(8'h3C, got);
    check(misoOe, 1'b0);
    apb(12'h314, 1'b0, 8'h00);
    check(rd[7], 1'b0);
    slaveSelN <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(misoOe, 1'b1);
    b = 8'($random(seed));
    sByte(b, got);
    check(got, 8'h00);
    rdChk(12'h318, b);
    sByte(~b, got);
    rdChk(12'h318, b);
    apb(12'h314, 1'b0, 8'h00);
    check(rd[7], 1'b1);
    summarize();
  end
endmodule
bind serial_port serial_port_checker i_serial_port_checker (.*);
